/* design/npe_pkg.sv */
package npe_pkg;
    // Bus widths and array geometry
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int BUF_AW = 9;
    localparam int CNT_W = 10;
    localparam int BLK_LSB = 16;
    localparam int PGM_W = ADDR_W + DATA_W;
    localparam logic [CNT_W-1:0] BUF_WORDS = 10'h200;
    localparam logic [DATA_W-1:0] MAX_COUNT_FIELD = 16'h01ff;
    localparam logic [BUF_AW-1:0] BUF_ALIGN = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

    // Command codes
    localparam logic [7:0] CMD_WORD_PGM = 8'h40;
    localparam logic [7:0] CMD_WORD_PGM_ALT = 8'h10;
    localparam logic [7:0] CMD_BUF_PGM = 8'he8;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_FACTORY = 8'h80;
    localparam logic [7:0] CMD_RD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0] CMD_RD_ARRAY = 8'hff;
    localparam logic [7:0] CMD_RD_ID = 8'h90;
    localparam logic [7:0] CMD_RD_CFI = 8'h98;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;

    // Status bit positions
    localparam int SR_READY = 7;
    localparam int SR_SEQ_ERR = 5;
    localparam int SR_PGM_FAIL = 4;
    localparam int SR_VPP_ERR = 3;
    localparam int SR_LOCK_ERR = 1;
    localparam int SR_BUF_BUSY = 0;
    localparam logic [7:0] SR_RESET = 8'h80;

    // Read modes shown to the read path
    typedef enum logic [3:0] {
        RM_ARRAY = 4'h1,
        RM_STATUS = 4'h2,
        RM_ID = 4'h4,
        RM_CFI = 4'h8
    } npe_rmode_e;

    // Command engine states
    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_WP_DATA = 11'h002,
        ST_WP_RUN = 11'h004,
        ST_BP_COUNT = 11'h008,
        ST_BP_DATA = 11'h010,
        ST_BP_CONFIRM = 11'h020,
        ST_BP_RUN = 11'h040,
        ST_FP_CONFIRM = 11'h080,
        ST_FP_SETUP = 11'h100,
        ST_FP_FILL = 11'h200,
        ST_FP_RUN = 11'h400
    } npe_state_e;
endpackage

/* design/npe_buf_mem.sv */
// Write buffer storage, registered read data
module npe_buf_mem
    import npe_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write side
    input wire logic we,
    input wire logic [BUF_AW-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    // Read side
    input wire logic re,
    input wire logic [BUF_AW-1:0] raddr,
    output logic [DATA_W-1:0] rdata_q
);
    logic [DATA_W-1:0] mem_q [0:(1<<BUF_AW)-1];

    // Storage write
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge clk)
    begin
        if (re)
        begin
            rdata_q <= mem_q[raddr];
        end
    end
endmodule // npe_buf_mem

/* design/npe_skid.sv */
// Two-entry buffer with valid/ready on both sides
module npe_skid
    import npe_pkg::*;
#(
    parameter int WIDTH = PGM_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot_q [0:1];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = slot_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Slot storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // npe_skid

/* design/npe_engine.sv */
module npe_engine
    import npe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host bus write cycle
    input wire logic wr_en,
    input wire logic [npe_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [npe_pkg::DATA_W-1:0] wr_data,
    // Block and supply condition
    input wire logic block_locked,
    input wire logic program_voltage_lockout,
    // Read path selection and status
    output npe_pkg::npe_rmode_e read_mode_q,
    output logic [7:0] status_q,
    // Array program port
    output logic pgm_valid,
    input wire logic pgm_ready,
    output logic [npe_pkg::ADDR_W-1:0] pgm_addr,
    output logic [npe_pkg::DATA_W-1:0] pgm_clear_mask,
    input wire logic pgm_fail
);
    import npe_pkg::*;

    function automatic logic [ADDR_W-BLK_LSB-1:0] blk(
        input logic [ADDR_W-1:0] a);
        blk = a[ADDR_W-1:BLK_LSB];
    endfunction

    npe_state_e state_q, state_d;
    npe_rmode_e mode_d;
    logic [ADDR_W-1:0] start_q;
    logic [ADDR_W-1:0] wa0_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] loaded_q;
    logic [CNT_W-1:0] idx_q;
    logic [BUF_AW-1:0] rd_idx_q;
    logic rd_pend_q;
    logic set_seq, set_fail, set_vpp, set_lock, clr_sts;
    logic eng_start, abort, engine_done, issue;
    logic mem_we;
    logic [BUF_AW-1:0] mem_waddr;
    logic [ADDR_W-1:0] first_end;
    logic [ADDR_W-1:0] wr_off;
    logic [DATA_W-1:0] mem_rdata;
    logic q_in_valid, q_in_ready;
    logic [PGM_W-1:0] q_in_data, q_out_data;
    logic [7:0] cmd;

    assign cmd = wr_data[7:0];
    assign first_end = wr_addr + ADDR_W'(cnt_q - CNT_ONE);
    assign wr_off = wr_addr - start_q;
    assign issue = (state_q == ST_BP_RUN || state_q == ST_FP_RUN)
        && (idx_q != cnt_q) && q_in_ready && !rd_pend_q;
    assign engine_done = (idx_q == cnt_q) && !rd_pend_q && !pgm_valid;

    // Command decode and sequencing
    always_comb
    begin
        state_d = state_q;
        mode_d = read_mode_q;
        {set_seq, set_fail, set_vpp, set_lock, clr_sts} = 5'h00;
        {eng_start, abort, mem_we} = 3'h0;
        mem_waddr = loaded_q[BUF_AW-1:0];
        unique case (state_q)
            ST_IDLE:
            begin
                if (wr_en)
                begin
                    unique case (cmd)
                        CMD_WORD_PGM, CMD_WORD_PGM_ALT:
                        begin
                            state_d = ST_WP_DATA;
                            mode_d = RM_STATUS;
                        end
                        CMD_BUF_PGM:
                        begin
                            state_d = ST_BP_COUNT;
                            mode_d = RM_STATUS;
                        end
                        CMD_FACTORY:
                        begin
                            state_d = ST_FP_CONFIRM;
                            mode_d = RM_STATUS;
                        end
                        CMD_CLR_STATUS: clr_sts = 1'b1;
                        CMD_RD_STATUS: mode_d = RM_STATUS;
                        CMD_RD_ARRAY: mode_d = RM_ARRAY;
                        CMD_RD_ID: mode_d = RM_ID;
                        CMD_RD_CFI: mode_d = RM_CFI;
                        default: ;
                    endcase
                end
            end
            ST_WP_DATA:
            begin
                if (wr_en)
                begin
                    state_d = ST_IDLE;
                    if (block_locked)
                    begin
                        {set_fail, set_lock} = 2'h3;
                    end
                    else if (program_voltage_lockout)
                    begin
                        {set_fail, set_vpp} = 2'h3;
                    end
                    else
                    begin
                        state_d = ST_WP_RUN;
                    end
                end
            end
            ST_BP_COUNT:
            begin
                if (wr_en)
                begin
                    if (wr_data > MAX_COUNT_FIELD)
                    begin
                        {set_seq, set_fail} = 2'h3;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        state_d = ST_BP_DATA;
                    end
                end
            end
            ST_BP_DATA:
            begin
                if (wr_en)
                begin
                    if (loaded_q == CNT_ZERO)
                    begin
                        mem_waddr = {BUF_AW{1'b0}};
                        if (blk(wr_addr) != blk(first_end))
                        begin
                            {set_seq, set_fail} = 2'h3;
                            state_d = ST_IDLE;
                        end
                        else
                        begin
                            mem_we = 1'b1;
                        end
                    end
                    else
                    begin
                        mem_waddr = wr_off[BUF_AW-1:0];
                        mem_we = (wr_off < ADDR_W'(cnt_q));
                    end
                    if (mem_we && (loaded_q + CNT_ONE == cnt_q))
                    begin
                        state_d = ST_BP_CONFIRM;
                    end
                end
            end
            ST_BP_CONFIRM:
            begin
                if (wr_en)
                begin
                    state_d = ST_IDLE;
                    if (cmd != CMD_CONFIRM)
                    begin
                        {set_seq, set_fail} = 2'h3;
                    end
                    else if (block_locked)
                    begin
                        {set_fail, set_lock} = 2'h3;
                    end
                    else if (program_voltage_lockout)
                    begin
                        {set_fail, set_vpp} = 2'h3;
                    end
                    else
                    begin
                        state_d = ST_BP_RUN;
                        eng_start = 1'b1;
                    end
                end
            end
            ST_FP_CONFIRM:
            begin
                if (wr_en)
                begin
                    state_d = ST_IDLE;
                    if (cmd != CMD_CONFIRM)
                    begin
                        {set_seq, set_fail} = 2'h3;
                    end
                    else if (block_locked)
                    begin
                        {set_fail, set_lock} = 2'h3;
                    end
                    else if (program_voltage_lockout)
                    begin
                        {set_fail, set_vpp} = 2'h3;
                    end
                    else if (wa0_q[BUF_AW-1:0] != BUF_ALIGN)
                    begin
                        set_fail = 1'b1;
                    end
                    else
                    begin
                        state_d = ST_FP_SETUP;
                    end
                end
            end
            ST_FP_SETUP: state_d = ST_FP_FILL;
            ST_FP_FILL:
            begin
                if (wr_en)
                begin
                    if (blk(wr_addr) != blk(wa0_q))
                    begin
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        mem_we = 1'b1;
                        if (loaded_q + CNT_ONE == BUF_WORDS)
                        begin
                            state_d = ST_FP_RUN;
                            eng_start = 1'b1;
                        end
                    end
                end
            end
            ST_WP_RUN, ST_BP_RUN, ST_FP_RUN:
            begin
                if (wr_en && state_q != ST_FP_RUN)
                begin
                    unique case (cmd)
                        CMD_RD_STATUS: mode_d = RM_STATUS;
                        CMD_RD_ARRAY: mode_d = RM_ARRAY;
                        CMD_RD_ID: mode_d = RM_ID;
                        CMD_RD_CFI: mode_d = RM_CFI;
                        default: ;
                    endcase
                end
                if (pgm_fail)
                begin
                    set_fail = 1'b1;
                    abort = 1'b1;
                    state_d = ST_IDLE;
                end
                else if (state_q == ST_WP_RUN ? !pgm_valid : engine_done)
                begin
                    state_d = (state_q == ST_FP_RUN) ? ST_FP_FILL : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State and read mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            read_mode_q <= RM_ARRAY;
        end
        else
        begin
            state_q <= state_d;
            read_mode_q <= mode_d;
        end
    end

    // Sequence bookkeeping: start, count, words loaded
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            start_q <= {ADDR_W{1'b0}};
            wa0_q <= {ADDR_W{1'b0}};
            cnt_q <= CNT_ZERO;
            loaded_q <= CNT_ZERO;
        end
        else
        begin
            if (state_q == ST_BP_COUNT && wr_en)
            begin
                cnt_q <= wr_data[CNT_W-1:0] + CNT_ONE;
                loaded_q <= CNT_ZERO;
            end
            if (state_q == ST_BP_DATA && mem_we)
            begin
                loaded_q <= loaded_q + CNT_ONE;
                if (loaded_q == CNT_ZERO)
                begin
                    start_q <= wr_addr;
                end
            end
            if (state_q == ST_IDLE && wr_en && cmd == CMD_FACTORY)
            begin
                wa0_q <= wr_addr;
            end
            if (state_q == ST_FP_SETUP)
            begin
                start_q <= wa0_q;
                cnt_q <= BUF_WORDS;
                loaded_q <= CNT_ZERO;
            end
            if (state_q == ST_FP_FILL && mem_we)
            begin
                loaded_q <= (state_d == ST_FP_RUN) ? CNT_ZERO
                    : loaded_q + CNT_ONE;
            end
            if (state_q == ST_FP_RUN && state_d == ST_FP_FILL)
            begin
                // Next buffer boundary, wrapping inside the block
                start_q[BLK_LSB-1:0] <= start_q[BLK_LSB-1:0]
                    + BLK_LSB'(BUF_WORDS);
            end
        end
    end

    // Buffer-to-array transfer engine
    always_ff @(posedge clk)
    begin
        if (!rst_n || abort)
        begin
            idx_q <= CNT_ZERO;
            rd_idx_q <= {BUF_AW{1'b0}};
            rd_pend_q <= 1'b0;
        end
        else
        begin
            if (eng_start)
            begin
                idx_q <= CNT_ZERO;
            end
            else if (issue)
            begin
                idx_q <= idx_q + CNT_ONE;
                rd_idx_q <= idx_q[BUF_AW-1:0];
            end
            rd_pend_q <= issue;
        end
    end

    // Status register: sets win over clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status_q <= SR_RESET;
        end
        else
        begin
            status_q[SR_READY] <= (state_d != ST_WP_RUN)
                && (state_d != ST_BP_RUN) && (state_d != ST_FP_SETUP)
                && (state_d != ST_FP_FILL) && (state_d != ST_FP_RUN);
            status_q[SR_BUF_BUSY] <= (state_d == ST_FP_RUN)
                || (state_d == ST_FP_SETUP);
            status_q[SR_SEQ_ERR] <= set_seq
                || (status_q[SR_SEQ_ERR] && !clr_sts);
            status_q[SR_PGM_FAIL] <= set_fail
                || (status_q[SR_PGM_FAIL] && !clr_sts);
            status_q[SR_VPP_ERR] <= set_vpp
                || (status_q[SR_VPP_ERR] && !clr_sts);
            status_q[SR_LOCK_ERR] <= set_lock
                || (status_q[SR_LOCK_ERR] && !clr_sts);
            status_q[6] <= 1'b0;
            status_q[2] <= 1'b0;
        end
    end

    // Word into the output buffer: direct word or buffer read-back
    assign q_in_valid = rd_pend_q
        || (state_q == ST_WP_DATA && state_d == ST_WP_RUN);
    assign q_in_data = rd_pend_q
        ? {start_q + ADDR_W'(rd_idx_q), mem_rdata}
        : {wr_addr, wr_data};

    npe_buf_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(wr_data),
        .re(issue),
        .raddr(idx_q[BUF_AW-1:0]),
        .rdata_q(mem_rdata)
    );

    npe_skid #(.WIDTH(PGM_W)) u_skid (
        .clk(clk),
        .rst_n(rst_n),
        .flush(abort),
        .in_valid(q_in_valid),
        .in_ready(q_in_ready),
        .in_data(q_in_data),
        .out_valid(pgm_valid),
        .out_ready(pgm_ready),
        .out_data(q_out_data)
    );

    // Only zeros are driven into the array
    assign pgm_addr = q_out_data[PGM_W-1:DATA_W];
    assign pgm_clear_mask = ~q_out_data[DATA_W-1:0];
endmodule // npe_engine

/* testbench/npe_engine_properties.sv */
module npe_engine_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host writes and conditions
    input wire logic wr_en,
    input wire logic [npe_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [npe_pkg::DATA_W-1:0] wr_data,
    input wire logic block_locked,
    input wire logic program_voltage_lockout,
    // Status and array port
    input npe_pkg::npe_rmode_e read_mode_q,
    input wire logic [7:0] status_q,
    input wire logic pgm_valid,
    input wire logic pgm_ready,
    input wire logic [npe_pkg::ADDR_W-1:0] pgm_addr,
    input wire logic [npe_pkg::DATA_W-1:0] pgm_clear_mask,
    input wire logic pgm_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    import npe_pkg::*;
    logic idle;
    // At rest: array reads, ready, nothing queued
    assign idle = read_mode_q == RM_ARRAY && status_q[7] && !pgm_valid;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Command steps
    sequence word_setup_s;
        idle && wr_en && wr_data[7:0] == CMD_WORD_PGM;
    endsequence
    sequence fp_cmd_s;
        idle && wr_en && wr_data[7:0] == CMD_FACTORY ##1
        wr_en && wr_data[7:0] == CMD_CONFIRM && !block_locked &&
        !program_voltage_lockout;
    endsequence
    reset_state_a: assert property ($rose(rst_n) |-> status_q == SR_RESET
        && read_mode_q == RM_ARRAY && !pgm_valid)
        else $error("status or mode wrong after reset");
    word_start_a: assert property (word_setup_s ##1 (wr_en && !block_locked
        && !program_voltage_lockout) |=> pgm_valid && !status_q[7] &&
        read_mode_q == RM_STATUS && pgm_addr == $past(wr_addr) &&
        pgm_clear_mask == ~$past(wr_data))
        else $error("word program did not start");
    word_lock_a: assert property (word_setup_s ##1 (wr_en && block_locked)
        |=> ##[0:1] (status_q[4] && status_q[1] && !pgm_valid))
        else $error("locked block not refused");
    word_hold_a: assert property (pgm_valid && !pgm_ready && !pgm_fail
        |=> pgm_valid && $stable(pgm_addr) && $stable(pgm_clear_mask))
        else $error("array word dropped before accept");
    busy_flag_a: assert property (pgm_valid |-> !status_q[SR_READY])
        else $error("ready set while programming");
    error_sticky_a: assert property (
        (|($past(status_q) & ~status_q & 8'h3a)) |->
        $past(wr_en) && $past(wr_data[7:0]) == CMD_CLR_STATUS)
        else $error("error bit fell without clear");
    clear_status_a: assert property (idle && wr_en &&
        wr_data[7:0] == CMD_CLR_STATUS |=> status_q == SR_RESET)
        else $error("clear status failed");
    buf_setup_a: assert property (idle && wr_en &&
        wr_data[7:0] == CMD_BUF_PGM |=> status_q[SR_READY] &&
        read_mode_q == RM_STATUS)
        else $error("buffer setup status wrong");
    fp_start_a: assert property (fp_cmd_s ##0 wr_addr[8:0] == BUF_ALIGN
        |=> !status_q[SR_READY] && status_q[SR_BUF_BUSY])
        else $error("factory setup not busy");
    fp_align_a: assert property (fp_cmd_s ##0 wr_addr[8:0] != BUF_ALIGN
        |=> ##[0:1] status_q[SR_PGM_FAIL])
        else $error("misaligned factory start accepted");
endmodule // npe_engine_chk

bind npe_engine npe_engine_chk u_chk (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .block_locked(block_locked),
    .program_voltage_lockout(program_voltage_lockout),
    .read_mode_q(read_mode_q), .status_q(status_q), .pgm_valid(pgm_valid),
    .pgm_ready(pgm_ready), .pgm_addr(pgm_addr),
    .pgm_clear_mask(pgm_clear_mask), .pgm_fail(pgm_fail));

/* testbench/npe_array_model.sv */
module npe_array_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench controls
    input wire logic slow,
    input wire logic fail_req,
    // Array program port
    input wire logic pgm_valid,
    output logic pgm_ready,
    input wire logic [npe_pkg::ADDR_W-1:0] pgm_addr,
    input wire logic [npe_pkg::DATA_W-1:0] pgm_clear_mask,
    output logic pgm_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    import npe_pkg::*;
    // Ready every cycle, or at random when slow
    always @(posedge clk)
    begin
        pgm_ready <= rst_n && (!slow || $urandom_range(1) == 1);
        pgm_fail <= rst_n && fail_req && pgm_valid && pgm_ready;
    end
endmodule // npe_array_model

/* testbench/testbench.sv */
`define CHK(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t: got %h expected %h", $time, a, b); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import npe_pkg::*;
    // Host side
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, block_locked = 1'b0;
    logic program_voltage_lockout = 1'b0, slow = 1'b0, fail_req = 1'b0;
    logic [ADDR_W-1:0] wr_addr = '0, a;
    logic [DATA_W-1:0] wr_data = '0, d;
    // Design outputs and bookkeeping
    npe_rmode_e read_mode_q;
    logic [7:0] status_q;
    logic pgm_valid, pgm_ready, pgm_fail;
    logic [ADDR_W-1:0] pgm_addr;
    logic [DATA_W-1:0] pgm_clear_mask;
    logic [PGM_W-1:0] exp_q [$], e_w;
    logic [7:0] cmds [4] = '{8'h70, 8'h90, 8'h98, 8'hff};
    npe_rmode_e modes [4] = '{RM_STATUS, RM_ID, RM_CFI, RM_ARRAY};
    int n_mismatch = 0, n_checks = 0, cyc = 0, i, k;

    always #2 clk = ~clk;

    npe_engine DUT (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .block_locked(block_locked),
        .program_voltage_lockout(program_voltage_lockout),
        .read_mode_q(read_mode_q), .status_q(status_q),
        .pgm_valid(pgm_valid), .pgm_ready(pgm_ready), .pgm_addr(pgm_addr),
        .pgm_clear_mask(pgm_clear_mask), .pgm_fail(pgm_fail));
    npe_array_model u_array (.clk(clk), .rst_n(rst_n), .slow(slow),
        .fail_req(fail_req), .pgm_valid(pgm_valid), .pgm_ready(pgm_ready),
        .pgm_addr(pgm_addr), .pgm_clear_mask(pgm_clear_mask),
        .pgm_fail(pgm_fail));

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One bus write, strobe left high for back to back use
    task wr(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = wa;
        wr_data = wd;
    endtask
    task idl;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    // Wait for ready with nothing queued, or for buffer done
    task settle(input bit on_b0);
        int j;
        repeat (2) @(negedge clk);
        for (j = 0; j < 3000 && (on_b0 ? status_q[0] !== 1'b0 :
            !(status_q[7] === 1'b1 && pgm_valid === 1'b0)); j++)
            @(negedge clk);
        // A wait that runs out is a failure of its own
        if (j == 3000)
            n_mismatch++;
    endtask
    // Errors survive a mode change, then clear
    task clr(input logic [7:0] e);
        wr(0, 16'h00ff);
        idl;
        `CHK(status_q, e)
        wr(0, 16'h0050);
        idl;
        `CHK(status_q, SR_RESET)
    endtask
    // Buffered setup, count and data; start aligned by caller
    task buf_load(input logic [ADDR_W-1:0] s, input int n);
        int j;
        wr(s, 16'h00e8);
        wr(s, DATA_W'(n - 1));
        for (j = 0; j < n; j++)
        begin
            d = DATA_W'($urandom);
            wr(s + ADDR_W'(j), d);
            exp_q.push_back({s + ADDR_W'(j), ~d});
        end
    endtask
    task tdone(input string s);
        $display("test %s finished", s);
    endtask

    // Each accepted array word against the oldest expectation
    always @(posedge clk)
    begin
        if (rst_n && pgm_valid && pgm_ready)
        begin
            e_w = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            `CHK({pgm_addr, pgm_clear_mask}, e_w)
        end
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_of_test;
        end
    end

    initial
    begin
        void'($urandom(8));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        `CHK(status_q, SR_RESET)
        foreach (cmds[j])
        begin
            wr(0, {8'h00, cmds[j]});
            idl;
            `CHK(read_mode_q, modes[j])
        end
        tdone("modes");
        slow = 1'b1;
        a = 26'h0031234;
        d = DATA_W'($urandom);
        wr(a, 16'h0040);
        wr(a, d);
        exp_q.push_back({a, ~d});
        wr(a, 16'h0090);
        idl;
        `CHK(read_mode_q, RM_ID)
        `CHK(status_q[7], 1'b0)
        settle(0);
        `CHK(status_q, SR_RESET)
        clr(SR_RESET);
        for (k = 0; k < 2; k++)
        begin
            wr(a, k == 0 ? 16'h0040 : 16'h0010);
            block_locked = (k == 0);
            program_voltage_lockout = (k == 1);
            wr(a, 16'h1234);
            idl;
            block_locked = 1'b0;
            program_voltage_lockout = 1'b0;
            settle(0);
            `CHK(status_q, k == 0 ? 8'h92 : 8'h98)
            clr(status_q);
        end
        tdone("word");
        buf_load(26'h0020200, 512);
        wr(26'h0020200, 16'h00d0);
        idl;
        settle(0);
        `CHK(status_q, SR_RESET)
        `CHK(exp_q.size(), 0)
        tdone("buffer");
        for (k = 0; k < 3; k++)
        begin
            a = (k == 2) ? 26'h002fffe : 26'h0020200;
            wr(a, 16'h00e8);
            wr(a, k == 0 ? 16'h0200 : (k == 1 ? 16'h0000 : 16'h0003));
            if (k > 0)
                wr(a, 16'h5a5a);
            if (k == 1)
                wr(a, 16'h0040);
            idl;
            settle(0);
            `CHK(status_q & 8'hb0, 8'hb0)
            clr(status_q);
        end
        exp_q.delete();
        program_voltage_lockout = 1'b1;
        buf_load(26'h0020200, 2);
        wr(26'h0020200, 16'h00d0);
        idl;
        program_voltage_lockout = 1'b0;
        settle(0);
        `CHK(status_q, 8'h98)
        clr(status_q);
        exp_q.delete();
        fail_req = 1'b1;
        buf_load(26'h0020200, 8);
        wr(26'h0020200, 16'h00d0);
        idl;
        settle(0);
        fail_req = 1'b0;
        exp_q.delete();
        `CHK(status_q, 8'h90)
        clr(status_q);
        tdone("errors");
        a = 26'h0050400;
        wr(a, 16'h00ff);
        wr(a, 16'h0080);
        wr(a, 16'h00d0);
        idl;
        settle(1);
        `CHK(status_q[7], 1'b0)
        for (k = 0; k < 2; k++)
        begin
            for (i = 0; i < 512; i++)
            begin
                d = DATA_W'($urandom);
                wr(a, d);
                exp_q.push_back({a + ADDR_W'(k * 512 + i), ~d});
            end
            idl;
            settle(1);
            `CHK(exp_q.size(), 0)
        end
        wr(26'h0060000, 16'hffff);
        idl;
        settle(0);
        `CHK(status_q, SR_RESET)
        wr(a + 4, 16'h00ff);
        wr(a + 4, 16'h0080);
        wr(a + 4, 16'h00d0);
        idl;
        settle(0);
        `CHK(status_q[4], 1'b1)
        clr(status_q);
        tdone("factory");
        end_of_test;
    end
endmodule // testbench
